// File: core/sacc_consts.vh
`ifndef SACC_CONSTS_VH
`define SACC_CONSTS_VH
// ----------------------------------------
// control register fields
// ----------------------------------------
`define SACC_CTRL_W 4
`define SACC_CTRL_RST 4'h0
`define SACC_MODE_BIT 3
`define SACC_SEL_HI 1
`define SACC_SEL_LO 0
`define SACC_SEL_CH0 2'h0
`define SACC_SEL_CH1 2'h1
// ----------------------------------------
// timing in machine cycles
// ----------------------------------------
`define SACC_CONV_CYCLES 62
`define SACC_CMP_CYCLES 8
`define SACC_CNT_W 6
`define SACC_STEP_SPACING 6'h6
`define SACC_FIRST_STEP 6'h3
`define SACC_TOP_TRIAL 10'h200
`define SACC_IDX_TOP 4'h9
`define SACC_IDX_LAST 4'h0
`define SACC_IDX_NONE 4'hF
// ----------------------------------------
// widths and resets
// ----------------------------------------
`define SACC_RES_W 10
`define SACC_CMPV_W 8
`define SACC_NIB_W 4
`define SACC_RES_RST 10'h000
`define SACC_CMPV_RST 8'h00
`endif

// File: core/sacc_sync2.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-stage level synchroniser
// ----------------------------------------
module sacc_sync2 (
    input wire mclk,
    input wire nrst,
    input wire din,
    output reg dout
);
reg stage1;
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        stage1 <= 1'b0;
        dout <= 1'b0;
    end else begin
        stage1 <= din;
        dout <= stage1;
    end
end
endmodule // sacc_sync2
`default_nettype wire

// File: core/sacc_ctrl.v
// Operation
// - mode bit zero selects conversion
// - mode bit one selects comparator
// - ten-bit result register holds conversions
// - high fetch gives upper eight bits
// - low fetch gives bits, lows zero
// - conversion dac equals result over 1024
// - flag clears on interrupt or skip
// - start begins conversion, result auto stored
// - clear result, set top, compare
// - keep bit if trial below input
// - finish at 62 cycles, set flag
// - compare value loads from B, A
// - comparator value kept across modes
// - compare value accessed only comparator mode
// - comparator dac equals value over 256
// - comparator flag set when input at or below value
// - comparison ends after eight cycles
// - switch may set flag; skip clears
// - select 00 chan zero, 01 one
`timescale 1ns/1ps
`default_nettype none
`include "sacc_consts.vh"
module sacc_ctrl #(
    parameter CONV_CYCLES = `SACC_CONV_CYCLES,
    parameter CMP_CYCLES = `SACC_CMP_CYCLES
) (
    input wire mclk,
    input wire nrst,
    input wire ctrl_we,
    input wire [3:0] ctrl_wdata,
    input wire start_convert_op,
    input wire fetch_result_high_op,
    input wire fetch_result_low_op,
    input wire skip_if_done_op,
    input wire write_compare_value_op,
    input wire read_compare_value_op,
    input wire int_taken,
    input wire [3:0] acc_a,
    input wire [3:0] acc_b,
    input wire cmp_trial_below_input,
    output reg [3:0] converter_control_reg,
    output reg conv_done_flag,
    output reg skip_taken,
    output reg [3:0] acc_a_out,
    output reg [3:0] acc_b_out,
    output reg acc_a_we,
    output reg acc_b_we,
    output reg [9:0] dac_code,
    output reg dac_fine,
    output reg analog_chan_zero,
    output reg analog_chan_one,
    output reg busy
);
// ----------------------------------------
// state
// ----------------------------------------
localparam ST_IDLE = 2'b00;
localparam ST_CONV = 2'b01;
localparam ST_CMP = 2'b10;
reg [1:0] state;
reg [`SACC_CNT_W-1:0] cnt;
reg [9:0] sar_result;
reg [7:0] comparator_value;
reg [3:0] bit_idx;
reg cmp_seen_done;
reg [1:0] next_state;
reg [`SACC_CNT_W-1:0] next_cnt;
reg [3:0] next_bit_idx;
reg [9:0] next_sar;
reg next_busy;
reg next_flag;
reg [3:0] next_acc_a;
reg [3:0] next_acc_b;
reg next_a_we;
reg next_b_we;
reg [9:0] next_dac;
reg next_fine;
wire [`SACC_CNT_W-1:0] step_off;
wire step_due;
wire mode_left_cmp;
wire cmpv_wr_ok;
wire cmpv_rd_ok;
wire sel_ch0;
wire sel_ch1;
wire trial_below;
wire mode_cmp;
wire step_now;
wire cnt_last;
wire set_conv_done;
wire set_cmp_done;
wire clr_flag;
// ----------------------------------------
// comparator input sync
// ----------------------------------------
sacc_sync2 u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din(cmp_trial_below_input),
    .dout(trial_below)
);
assign mode_cmp = converter_control_reg[`SACC_MODE_BIT];
assign step_due = (cnt >= `SACC_FIRST_STEP);
assign step_off = cnt - `SACC_FIRST_STEP;
assign step_now = (state == ST_CONV) && (bit_idx != `SACC_IDX_NONE) &&
    step_due && ((step_off % `SACC_STEP_SPACING) == {`SACC_CNT_W{1'b0}});
assign cnt_last = (state == ST_CONV) ? (cnt == CONV_CYCLES - 1) :
    (cnt == CMP_CYCLES - 1);
assign set_conv_done = (state == ST_CONV) && cnt_last;
assign set_cmp_done = (state == ST_CMP) && cnt_last && !trial_below;
assign clr_flag = int_taken || skip_if_done_op;
// ----------------------------------------
// control register
// ----------------------------------------
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        converter_control_reg <= `SACC_CTRL_RST;
    end else if (ctrl_we) begin
        converter_control_reg <= ctrl_wdata;
    end
end
// ----------------------------------------
// sequencer
// ----------------------------------------
// start in idle launches run
always @* begin
    next_state = state;
    next_cnt = cnt;
    next_bit_idx = bit_idx;
    next_sar = sar_result;
    next_busy = busy;
    case (state)
        ST_IDLE: begin
            next_cnt = {`SACC_CNT_W{1'b0}};
            if (start_convert_op) begin
                next_busy = 1'b1;
                if (mode_cmp) begin
                    next_state = ST_CMP;
                end else begin
                    next_state = ST_CONV;
                    next_sar = `SACC_TOP_TRIAL;
                    next_bit_idx = `SACC_IDX_TOP;
                end
            end
        end
        ST_CONV, ST_CMP: begin
            next_cnt = cnt + 1'b1;
            if (step_now) begin
                if (!trial_below) begin
                    next_sar[bit_idx] = 1'b0;
                end
                if (bit_idx != `SACC_IDX_LAST) begin
                    next_sar[bit_idx - 1'b1] = 1'b1;
                    next_bit_idx = bit_idx - 1'b1;
                end else begin
                    next_bit_idx = `SACC_IDX_NONE;
                end
            end
            if (cnt_last) begin
                next_state = ST_IDLE;
                next_busy = 1'b0;
                next_bit_idx = `SACC_IDX_NONE;
            end
        end
        default: begin
            next_state = ST_IDLE;
            next_busy = 1'b0;
        end
    endcase
end
// ----------------------------------------
// sequencer registers
// ----------------------------------------
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        state <= ST_IDLE;
        cnt <= {`SACC_CNT_W{1'b0}};
        bit_idx <= `SACC_IDX_NONE;
        sar_result <= `SACC_RES_RST;
        busy <= 1'b0;
    end else begin
        state <= next_state;
        cnt <= next_cnt;
        bit_idx <= next_bit_idx;
        sar_result <= next_sar;
        busy <= next_busy;
    end
end
// ----------------------------------------
// done flag
// ----------------------------------------
// leaving comparator mode seen
assign mode_left_cmp = cmp_seen_done && !mode_cmp;
always @* begin
    next_flag = conv_done_flag;
    if (clr_flag) begin
        next_flag = 1'b0;
    end
    // set wins over clear
    if (set_conv_done || set_cmp_done || mode_left_cmp) begin
        next_flag = 1'b1;
    end
end
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        conv_done_flag <= 1'b0;
        skip_taken <= 1'b0;
        cmp_seen_done <= 1'b0;
    end else begin
        skip_taken <= skip_if_done_op && conv_done_flag;
        cmp_seen_done <= mode_cmp;
        conv_done_flag <= next_flag;
    end
end
// ----------------------------------------
// comparator value and transfers
// ----------------------------------------
// comparator mode only
assign cmpv_wr_ok = write_compare_value_op && mode_cmp;
assign cmpv_rd_ok = read_compare_value_op && mode_cmp;
always @* begin
    next_acc_a = acc_a_out;
    next_acc_b = acc_b_out;
    next_a_we = 1'b0;
    next_b_we = 1'b0;
    if (cmpv_rd_ok) begin
        next_acc_b = comparator_value[7:4];
        next_acc_a = comparator_value[3:0];
        next_a_we = 1'b1;
        next_b_we = 1'b1;
    end else if (fetch_result_high_op) begin
        next_acc_b = sar_result[9:6];
        next_acc_a = sar_result[5:2];
        next_a_we = 1'b1;
        next_b_we = 1'b1;
    end else if (fetch_result_low_op) begin
        next_acc_a = {sar_result[1:0], 2'b00};
        next_a_we = 1'b1;
    end
end
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        comparator_value <= `SACC_CMPV_RST;
    end else if (cmpv_wr_ok) begin
        comparator_value <= {acc_b, acc_a};
    end
end
// ----------------------------------------
// transfer registers
// ----------------------------------------
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        acc_a_out <= 4'h0;
        acc_b_out <= 4'h0;
        acc_a_we <= 1'b0;
        acc_b_we <= 1'b0;
    end else begin
        acc_a_out <= next_acc_a;
        acc_b_out <= next_acc_b;
        acc_a_we <= next_a_we;
        acc_b_we <= next_b_we;
    end
end
// ----------------------------------------
// dac code and input routing
// ----------------------------------------
always @* begin
    if (mode_cmp) begin
        next_dac = {comparator_value, 2'b00};
        next_fine = 1'b0;
    end else begin
        next_dac = sar_result;
        next_fine = 1'b1;
    end
end
assign sel_ch0 = (converter_control_reg[`SACC_SEL_HI:`SACC_SEL_LO] == `SACC_SEL_CH0);
assign sel_ch1 = (converter_control_reg[`SACC_SEL_HI:`SACC_SEL_LO] == `SACC_SEL_CH1);
// ----------------------------------------
// dac registers
// ----------------------------------------
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        dac_code <= `SACC_RES_RST;
        dac_fine <= 1'b0;
        analog_chan_zero <= 1'b0;
        analog_chan_one <= 1'b0;
    end else begin
        dac_code <= next_dac;
        dac_fine <= next_fine;
        analog_chan_zero <= sel_ch0;
        analog_chan_one <= sel_ch1;
    end
end
endmodule // sacc_ctrl
`default_nettype wire

// File: tb/sacc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// analog input and trial comparator
// ----------------------------------------
module sacc_analog_model (
    input wire logic [9:0] dac_code,
    input wire logic dac_fine,
    input wire logic [9:0] analog_input_voltage,
    output logic trial_below
);
    // pin latch held high
    // trial scaled to 1024 steps
    assign trial_below = (dac_fine ? dac_code : {dac_code[9:2], 2'h0}) < analog_input_voltage;
endmodule // sacc_analog_model
`default_nettype wire

// File: tb/sacc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl_checker #(
    parameter CONV_CYCLES = 62,
    parameter CMP_CYCLES = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start_convert_op,
    input wire logic fetch_result_high_op,
    input wire logic fetch_result_low_op,
    input wire logic skip_if_done_op,
    input wire logic int_taken,
    input wire logic [3:0] converter_control_reg,
    input wire logic conv_done_flag,
    input wire logic skip_taken,
    input wire logic [3:0] acc_a_out,
    input wire logic acc_a_we,
    input wire logic acc_b_we,
    input wire logic [9:0] dac_code,
    input wire logic dac_fine,
    input wire logic analog_chan_zero,
    input wire logic analog_chan_one,
    input wire logic busy
);
    localparam int CL = CONV_CYCLES - 2;
    localparam int CH = CONV_CYCLES + 1;
    localparam int ML = CMP_CYCLES - 2;
    localparam int MH = CMP_CYCLES + 1;
    wire md = converter_control_reg[3];
    wire go = start_convert_op && !busy;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    start_busy_a: assert property (go |=> busy)
        else $error("busy not raised");
    trial_top_a: assert property (go && !md |=> ##1 dac_code == 10'h200 && dac_fine)
        else $error("first trial wrong");
    conv_len_a: assert property (go && !md |-> ##[CL:CH] $fell(busy))
        else $error("conversion length wrong");
    cmp_len_a: assert property (go && md |-> ##[ML:MH] $fell(busy))
        else $error("comparison length wrong");
    flag_end_a: assert property ($fell(busy) && !md |-> conv_done_flag)
        else $error("flag not set at end");
    high_we_a: assert property (fetch_result_high_op |=> acc_a_we && acc_b_we)
        else $error("high fetch strobes");
    low_zero_a: assert property (fetch_result_low_op |=> acc_a_we && !acc_b_we && acc_a_out[1:0] == 2'h0)
        else $error("low fetch bits");
    skip_clr_a: assert property (skip_if_done_op && conv_done_flag && !busy |=> skip_taken && !conv_done_flag)
        else $error("skip did not clear");
    int_clr_a: assert property (int_taken && !busy |=> !conv_done_flag)
        else $error("interrupt did not clear");
    chan_route_a: assert property ($past(nrst) && $stable(converter_control_reg) |->
        analog_chan_zero == (converter_control_reg[1:0] == 2'h0) && analog_chan_one == (converter_control_reg[1:0] == 2'h1))
        else $error("input route wrong");
    cover property (go && !md);
    cover property (go && md);
    cover property (skip_taken);
endmodule // sacc_ctrl_checker
bind sacc_ctrl sacc_ctrl_checker #(.CONV_CYCLES(CONV_CYCLES), .CMP_CYCLES(CMP_CYCLES)) chk (.*);
`default_nettype wire

// File: tb/sacc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl_tb;
    logic mclk = 0, nrst = 0;
    logic [7:0] ops = 8'h00;
    logic [3:0] wd = 4'h0, acc_a = 4'h0, acc_b = 4'h0;
    logic [9:0] analog_input_voltage = 10'h000;
    wire [3:0] ctrl, a_out, b_out;
    wire [9:0] dac_code;
    wire flag, skip, a_we, b_we, fine, ch0, ch1, busy, below;
    integer num_errors = 0, tests_run = 0, seed = 59, i, res, cv;
    sacc_ctrl dut (.mclk(mclk), .nrst(nrst), .ctrl_we(ops[7]), .ctrl_wdata(wd),
        .start_convert_op(ops[0]), .fetch_result_high_op(ops[1]), .fetch_result_low_op(ops[2]),
        .skip_if_done_op(ops[3]), .write_compare_value_op(ops[4]),
        .read_compare_value_op(ops[5]), .int_taken(ops[6]), .acc_a(acc_a), .acc_b(acc_b),
        .cmp_trial_below_input(below), .converter_control_reg(ctrl), .conv_done_flag(flag),
        .skip_taken(skip), .acc_a_out(a_out), .acc_b_out(b_out), .acc_a_we(a_we),
        .acc_b_we(b_we), .dac_code(dac_code), .dac_fine(fine), .analog_chan_zero(ch0),
        .analog_chan_one(ch1), .busy(busy));
    sacc_analog_model far (.dac_code(dac_code), .dac_fine(fine), .analog_input_voltage(analog_input_voltage), .trial_below(below));
    task chk(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task op(input int k, input logic [7:0] d);
        @(posedge mclk);
        ops <= 8'h01 << k;
        wd <= d[3:0];
        acc_a <= d[3:0];
        acc_b <= d[7:4];
        @(posedge mclk);
        ops <= 8'h00;
        #1;
    endtask
    task run;
        op(0, 8'h00);
        for (i = 0; i < 80 && busy === 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (busy !== 1'b0) begin
            num_errors++;
            close_out;
        end
    endtask
    initial begin
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1;
        op(7, 8'h01);
        for (int t = 0; t < 5; t++) begin
            analog_input_voltage <= (t == 0) ? 10'h000 : (t == 1) ? 10'h3FF : 10'($random(seed));
            run;
            res = 0;
            for (i = 9; i >= 0; i--) if ((res | (1 << i)) < analog_input_voltage) res = res | (1 << i);
            chk(flag, 1);
            chk(dac_code, res);
            chk(fine, 1);
            op(1, 8'h00);
            chk({b_out, a_out}, res >> 2);
            op(2, 8'h00);
            chk(a_out, (res & 3) << 2);
            op(3, 8'h00);
            chk({skip, flag}, 2'b10);
        end
        chk({ch0, ch1}, 2'b01);
        op(7, 8'h08);
        for (int t = 0; t < 4; t++) begin
            cv = {$random(seed)} % 256;
            analog_input_voltage <= 10'($random(seed)) | 10'h001;
            op(4, cv[7:0]);
            run;
            chk(flag, analog_input_voltage < cv * 4);
            chk(dac_code, cv * 4);
            chk(fine, 0);
            op(5, 8'h00);
            chk({b_out, a_out}, cv);
            op(6, 8'h00);
            chk(flag, 0);
        end
        chk({ch0, ch1}, 2'b10);
        op(7, 8'h00);
        op(3, 8'h00);
        chk({skip, flag}, 2'b10);
        op(4, 8'h5A);
        op(7, 8'h08);
        op(5, 8'h00);
        chk({b_out, a_out}, cv);
        close_out;
    end
endmodule // sacc_ctrl_tb
`default_nettype wire
